// [rtl/cap_pkg.sv]
// Shared constants for the ALU-ops and shared-prescaler block.
// Assumes one 40 MHz clock and an AHB-Lite register port.
`default_nettype none
package cap_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_INSTR = 10'h000;
    localparam logic [IDX_W-1:0] IDX_ACC = 10'h001;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h002;
    localparam logic [IDX_W-1:0] IDX_TIMER = 10'h003;
    localparam logic [IDX_W-1:0] IDX_FADDR = 10'h004;
    localparam logic [IDX_W-1:0] IDX_FDATA = 10'h005;
    localparam logic [IDX_W-1:0] IDX_OPTION = 10'h081;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // ------------------------------------------------------------
    // Option and status fields, reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam int OPT_PS_LSB = 0;
    localparam int OPT_PSA_BIT = 3;
    localparam int OPT_TOSE_BIT = 4;
    localparam int OPT_TOCS_BIT = 5;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_SLEEP = 5;
    localparam logic TO_RESET = 1'b1;
    localparam logic PD_RESET = 1'b1;
    // ------------------------------------------------------------
    // File space and instruction encodings
    // ------------------------------------------------------------
    localparam int FILE_AW = 7;
    localparam int FILE_DEPTH = 128;
    localparam logic [FILE_AW-1:0] TIMER_FADDR = 7'h01;
    localparam logic [4:0] OPC_ADD_LIT = 5'h1F;
    localparam logic [4:0] OPC_SUB_LIT = 5'h1E;
    localparam logic [5:0] OPC_AND_LIT = 6'h39;
    localparam logic [5:0] OPC_ADD_REG = 6'h07;
    localparam logic [5:0] OPC_AND_REG = 6'h05;
    localparam logic [5:0] OPC_ROT_RIGHT = 6'h0C;
    localparam logic [13:0] OPC_SLEEP = 14'h0063;
    localparam logic [13:0] OPC_WDT_CLEAR = 14'h0064;
    // ------------------------------------------------------------
    // Phases and watchdog
    // ------------------------------------------------------------
    localparam logic [1:0] PH_SECOND = 2'h1;
    localparam logic [1:0] PH_FOURTH = 2'h3;
    localparam int WDT_WIDTH = 8;
    typedef enum logic {st_idle, st_exec} cap_state_t;
endpackage
`default_nettype wire

// [rtl/cap_file_mem.sv]
// File register memory with one write port and two read ports.
// Assumes a single clock; read data come out of registers.
`timescale 1ns/1ps
`default_nettype none
module cap_file_mem #(
    parameter int AW = 7,
    parameter int DEPTH = 128
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] a_addr,
    output logic [7:0] a_data,
    input wire logic [AW-1:0] b_addr,
    output logic [7:0] b_data
);
    logic [7:0] mem [DEPTH];
    logic [7:0] a_next;
    logic [7:0] b_next;

    // Write-first, so a read right after a write sees new data
    always_comb begin
        a_next = (we && waddr == a_addr) ? wdata : mem[a_addr];
        b_next = (we && waddr == b_addr) ? wdata : mem[b_addr];
    end

    // Array itself is not reset, only the read registers
    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_data <= 8'h00;
            b_data <= 8'h00;
        end else begin
            a_data <= a_next;
            b_data <= b_next;
        end
    end
endmodule
`default_nettype wire

// [rtl/cap_core.sv]
// ALU operations, status flags and shared timer/watchdog prescaler.
// Assumes an AHB-Lite master on hclk and a pin input for the timer.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Add literal adds k to accumulator, updates C, DC, Z.
// - Add register adds accumulator and file, result to destination, C/DC/Z.
// - Destination bit 0 selects accumulator, 1 the file; address 0..127.
// - AND with literal or register touches only the zero flag.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Literal minus accumulator; carry set when result is zero or positive.
// - One counter serves timer or watchdog, never both.
// - Option bits 3:0 pick assignment and division ratio.
// - Timer writes clear the counter while it belongs to the timer.
// - Watchdog clear also clears the counter while it serves watchdog.
// - Counter value is not reachable by software.
// - Output sampled in second and fourth phase; undivided means pass-through.
// - Timer increments a cycle after the synchronised edge.
module cap_core
    import cap_pkg::*;
#(
    parameter int WDT_W = WDT_WIDTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic timer_ext_clock_in,
    input wire logic wdt_enable,
    input wire logic wdt_tick,
    input wire logic wake_req,
    output logic osc_halt,
    output logic wdt_timeout
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cap_state_t state_reg, state_next;
    logic dp_valid_reg, dp_valid_next, dp_write_reg, dp_write_next;
    logic [IDX_W-1:0] dp_idx_reg, dp_idx_next;
    logic [31:0] rd_hold_reg, rd_hold_next;
    logic [13:0] instr_reg, instr_next;
    logic [7:0] acc_reg, acc_next, option_reg, option_next;
    logic [7:0] timer_reg, timer_next;
    logic [FILE_AW-1:0] file_addr_reg, file_addr_next;
    logic st_c_reg, st_c_next, st_dc_reg, st_dc_next, st_z_reg, st_z_next;
    logic st_to_reg, st_to_next, st_pd_reg, st_pd_next, asleep_reg, asleep_next;
    logic pin_ff1_reg, pin_ff2_reg, src_prev_reg, src_prev_next;
    logic [1:0] phase_reg, phase_next;
    logic [7:0] cnt_reg, cnt_next;
    logic samp_a_reg, samp_a_next, samp_b_reg, samp_b_next;
    logic samp_prev_reg, samp_prev_next, tmr_inc_reg, tmr_inc_next;
    logic [WDT_W-1:0] wdt_reg, wdt_next;
    logic wdt_tout_reg, wdt_tout_next;
    logic accept, wr_done, exec, scaler_assign_sel, psc_clr, wdt_clr, wdt_ovf, wdt_tout;
    logic src_level, src_rise, psc_out;
    logic [2:0] ps_sel;
    logic [7:0] ps_mask, k_lit, operand, src, a_in, b_in, alu_res, stat_word;
    logic [FILE_AW-1:0] f_addr;
    logic dest_file, reg_form, lit_form, arith, logic_op;
    logic add_literal_op, literal_minus_acc_op, and_literal_op;
    logic add_register_op, and_register_op, rotate_right_carry_op;
    logic watchdog_clear_op, sleep_op;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic mem_we;
    logic [FILE_AW-1:0] mem_waddr;
    logic [7:0] mem_wdata, mem_a_data, mem_b_data;

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    assign k_lit = instr_reg[7:0];
    assign f_addr = instr_reg[6:0];
    assign dest_file = instr_reg[7];
    assign add_literal_op = instr_reg[13:9] == OPC_ADD_LIT;
    assign literal_minus_acc_op = instr_reg[13:9] == OPC_SUB_LIT;
    assign and_literal_op = instr_reg[13:8] == OPC_AND_LIT;
    assign add_register_op = instr_reg[13:8] == OPC_ADD_REG;
    assign and_register_op = instr_reg[13:8] == OPC_AND_REG;
    assign rotate_right_carry_op = instr_reg[13:8] == OPC_ROT_RIGHT;
    assign watchdog_clear_op = instr_reg == OPC_WDT_CLEAR;
    assign sleep_op = instr_reg == OPC_SLEEP;
    assign lit_form = add_literal_op | literal_minus_acc_op | and_literal_op;
    assign reg_form = add_register_op | and_register_op | rotate_right_carry_op;
    assign arith = add_literal_op | literal_minus_acc_op | add_register_op;
    assign logic_op = and_literal_op | and_register_op;
    assign exec = state_reg == st_exec;

    // ------------------------------------------------------------
    // ALU datapath
    // ------------------------------------------------------------
    // Timer sits at file address 1, so the file read is bypassed there
    assign operand = (f_addr == TIMER_FADDR) ? timer_reg : mem_a_data;
    assign src = lit_form ? k_lit : operand;
    // Subtract as k + ~W + 1, so carry means no borrow
    assign a_in = literal_minus_acc_op ? k_lit : acc_reg;
    assign b_in = literal_minus_acc_op ? ~acc_reg : src;
    assign sum9 = {1'b0, a_in} + {1'b0, b_in} + {8'h00, literal_minus_acc_op};
    assign nib5 = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, literal_minus_acc_op};
    assign alu_res = logic_op ? (acc_reg & src) :
                     rotate_right_carry_op ? {st_c_reg, operand[7:1]} : sum9[7:0];

    // ------------------------------------------------------------
    // Bus slave: data phase tracking and read data
    // ------------------------------------------------------------
    assign accept = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
    assign hreadyout = !exec;
    assign hresp = 1'b0;
    assign wr_done = dp_valid_reg & dp_write_reg & hreadyout;
    assign hrdata = (dp_idx_reg == IDX_FDATA) ? {24'h000000, mem_b_data} : rd_hold_reg;

    // Read word tracks the next values, so a stalled read sees results
    always_comb begin
        dp_valid_next = dp_valid_reg;
        dp_write_next = dp_write_reg;
        dp_idx_next = dp_idx_reg;
        if (hready) begin
            dp_valid_next = accept;
            dp_write_next = hwrite;
            dp_idx_next = haddr[11:2];
        end
        stat_word = 8'h00;
        stat_word[ST_C] = st_c_next;
        stat_word[ST_DC] = st_dc_next;
        stat_word[ST_Z] = st_z_next;
        stat_word[ST_PD] = st_pd_next;
        stat_word[ST_TO] = st_to_next;
        stat_word[ST_SLEEP] = asleep_next;
        case (dp_idx_next)
            IDX_INSTR: rd_hold_next = {18'h00000, instr_next};
            IDX_ACC: rd_hold_next = {24'h000000, acc_next};
            IDX_STATUS: rd_hold_next = {24'h000000, stat_word};
            IDX_TIMER: rd_hold_next = {24'h000000, timer_next};
            IDX_FADDR: rd_hold_next = {25'h0000000, file_addr_next};
            IDX_OPTION: rd_hold_next = {24'h000000, option_next};
            default: rd_hold_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_idx_reg <= IDX_INSTR;
            rd_hold_reg <= 32'h00000000;
        end else begin
            dp_valid_reg <= dp_valid_next;
            dp_write_reg <= dp_write_next;
            dp_idx_reg <= dp_idx_next;
            rd_hold_reg <= rd_hold_next;
        end
    end

    // ------------------------------------------------------------
    // Core state: registers, execution, status flags
    // ------------------------------------------------------------
    always_comb begin
        state_next = st_idle;
        instr_next = instr_reg;
        acc_next = acc_reg;
        option_next = option_reg;
        file_addr_next = file_addr_reg;
        timer_next = tmr_inc_reg ? timer_reg + 8'h01 : timer_reg;
        st_c_next = st_c_reg;
        st_dc_next = st_dc_reg;
        st_z_next = st_z_reg;
        st_to_next = wdt_tout ? 1'b0 : st_to_reg;
        st_pd_next = st_pd_reg;
        asleep_next = asleep_reg & ~wake_req & ~wdt_tout;
        mem_we = 1'b0;
        mem_waddr = file_addr_reg;
        mem_wdata = hwdata[7:0];
        psc_clr = 1'b0;
        wdt_clr = 1'b0;
        if (wr_done) begin
            case (dp_idx_reg)
                IDX_INSTR: begin
                    // Held off while the oscillator is halted
                    if (!asleep_reg) begin
                        instr_next = hwdata[13:0];
                        state_next = st_exec;
                    end
                end
                IDX_ACC: acc_next = hwdata[7:0];
                IDX_STATUS: begin
                    st_c_next = hwdata[ST_C];
                    st_dc_next = hwdata[ST_DC];
                    st_z_next = hwdata[ST_Z];
                end
                IDX_TIMER: begin
                    timer_next = hwdata[7:0];
                    psc_clr = ~scaler_assign_sel;
                end
                IDX_FADDR: file_addr_next = hwdata[FILE_AW-1:0];
                IDX_FDATA: mem_we = 1'b1;
                IDX_OPTION: option_next = hwdata[7:0];
                default: ;
            endcase
        end
        if (exec) begin
            if (lit_form) begin
                acc_next = alu_res;
            end
            if (reg_form) begin
                if (!dest_file) begin
                    acc_next = alu_res;
                end else if (f_addr == TIMER_FADDR) begin
                    timer_next = alu_res;
                    psc_clr = ~scaler_assign_sel;
                end else begin
                    mem_we = 1'b1;
                    mem_waddr = f_addr;
                    mem_wdata = alu_res;
                end
            end
            if (arith) begin
                st_c_next = sum9[8];
                st_dc_next = nib5[4];
            end
            if (arith | logic_op) begin
                st_z_next = alu_res == 8'h00;
            end
            if (rotate_right_carry_op) begin
                st_c_next = operand[0];
            end
            if (watchdog_clear_op | sleep_op) begin
                wdt_clr = 1'b1;
                psc_clr = scaler_assign_sel;
                st_to_next = 1'b1;
                st_pd_next = watchdog_clear_op;
            end
            if (sleep_op) begin
                asleep_next = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= st_idle;
            instr_reg <= 14'h0000;
            acc_reg <= 8'h00;
            option_reg <= OPTION_RESET;
            file_addr_reg <= 7'h00;
            timer_reg <= 8'h00;
            st_c_reg <= 1'b0;
            st_dc_reg <= 1'b0;
            st_z_reg <= 1'b0;
            st_to_reg <= TO_RESET;
            st_pd_reg <= PD_RESET;
            asleep_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            instr_reg <= instr_next;
            acc_reg <= acc_next;
            option_reg <= option_next;
            file_addr_reg <= file_addr_next;
            timer_reg <= timer_next;
            st_c_reg <= st_c_next;
            st_dc_reg <= st_dc_next;
            st_z_reg <= st_z_next;
            st_to_reg <= st_to_next;
            st_pd_reg <= st_pd_next;
            asleep_reg <= asleep_next;
        end
    end

    assign osc_halt = asleep_reg;

    // ------------------------------------------------------------
    // Shared prescaler, watchdog and pin synchronisation
    // ------------------------------------------------------------
    assign scaler_assign_sel = option_reg[OPT_PSA_BIT];
    assign ps_sel = option_reg[OPT_PS_LSB +: 3];
    assign ps_mask = (8'h01 << ps_sel) - 8'h01;
    // Internal source is the instruction rate, one period per four phases
    assign src_level = option_reg[OPT_TOCS_BIT] ?
                       (pin_ff2_reg ^ option_reg[OPT_TOSE_BIT]) : phase_reg[1];
    assign src_rise = src_level & ~src_prev_reg;
    assign wdt_ovf = wdt_enable & wdt_tick & (&wdt_reg);
    // Timer side divides by 2^(ps+1), watchdog side by 2^ps
    assign wdt_tout = wdt_ovf & (~scaler_assign_sel | ((cnt_reg & ps_mask) == ps_mask));
    assign psc_out = scaler_assign_sel ? src_level : cnt_reg[ps_sel];
    assign wdt_timeout = wdt_tout_reg;

    always_comb begin
        phase_next = phase_reg + 2'h1;
        src_prev_next = src_level;
        wdt_next = wdt_reg;
        if (wdt_clr) begin
            wdt_next = '0;
        end else if (wdt_enable & wdt_tick) begin
            wdt_next = wdt_reg + 1'b1;
        end
        cnt_next = cnt_reg;
        if (psc_clr) begin
            cnt_next = 8'h00;
        end else if ((~scaler_assign_sel & src_rise) | (scaler_assign_sel & wdt_ovf)) begin
            cnt_next = cnt_reg + 8'h01;
        end
        samp_a_next = (phase_reg == PH_SECOND) ? psc_out : samp_a_reg;
        samp_b_next = (phase_reg == PH_FOURTH) ? samp_a_reg : samp_b_reg;
        samp_prev_next = samp_b_reg;
        // Extra register stage: count never lands on the pin edge
        tmr_inc_next = samp_b_reg & ~samp_prev_reg;
        wdt_tout_next = wdt_tout;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_ff1_reg <= 1'b0;
            pin_ff2_reg <= 1'b0;
            phase_reg <= 2'h0;
            // Edge chain starts at the idle source level, else reset fakes a count
            src_prev_reg <= OPTION_RESET[OPT_TOSE_BIT];
            wdt_reg <= '0;
            cnt_reg <= 8'h00;
            samp_a_reg <= OPTION_RESET[OPT_TOSE_BIT];
            samp_b_reg <= OPTION_RESET[OPT_TOSE_BIT];
            samp_prev_reg <= OPTION_RESET[OPT_TOSE_BIT];
            tmr_inc_reg <= 1'b0;
            wdt_tout_reg <= 1'b0;
        end else begin
            pin_ff1_reg <= timer_ext_clock_in;
            pin_ff2_reg <= pin_ff1_reg;
            phase_reg <= phase_next;
            src_prev_reg <= src_prev_next;
            wdt_reg <= wdt_next;
            cnt_reg <= cnt_next;
            samp_a_reg <= samp_a_next;
            samp_b_reg <= samp_b_next;
            samp_prev_reg <= samp_prev_next;
            tmr_inc_reg <= tmr_inc_next;
            wdt_tout_reg <= wdt_tout_next;
        end
    end

    // ------------------------------------------------------------
    // File register memory
    // ------------------------------------------------------------
    cap_file_mem #(
        .AW(FILE_AW),
        .DEPTH(FILE_DEPTH)
    ) u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .a_addr(instr_next[FILE_AW-1:0]),
        .a_data(mem_a_data),
        .b_addr(file_addr_next),
        .b_data(mem_b_data)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_add_lit_sum: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && add_literal_op |=> acc_reg == 8'($past(acc_reg) + $past(k_lit)))
        else $error("add literal result wrong");
    a_add_reg_carry: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && add_register_op |=> st_c_reg == (9'($past(acc_reg)) + 9'($past(operand)) > 9'h0FF) &&
        st_z_reg == (8'($past(acc_reg) + $past(operand)) == 8'h00))
        else $error("add register flags wrong");
    a_dest_select: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && reg_form && dest_file && f_addr != TIMER_FADDR |-> mem_we && mem_waddr == f_addr && acc_next == acc_reg)
        else $error("destination select wrong");
    a_and_zero_only: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && logic_op |=> $stable(st_c_reg) && $stable(st_dc_reg))
        else $error("and touched carry");
    a_rotate_carry: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && rotate_right_carry_op |=> st_c_reg == $past(operand[0]))
        else $error("rotate carry wrong");
    a_sub_carry: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && literal_minus_acc_op |=> st_c_reg == ($past(k_lit) >= $past(acc_reg)))
        else $error("subtract carry wrong");
    a_timer_wr_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_done && dp_idx_reg == IDX_TIMER && !scaler_assign_sel |=> cnt_reg == 8'h00)
        else $error("timer write kept prescaler");
    a_wdt_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && watchdog_clear_op && scaler_assign_sel |=> cnt_reg == 8'h00 && wdt_reg == '0 && st_to_reg)
        else $error("watchdog clear incomplete");
    a_sync_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(samp_b_reg) |-> $past(phase_reg) == PH_FOURTH)
        else $error("sample outside fourth phase");
    a_inc_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(samp_b_reg) |=> tmr_inc_reg ##1 !tmr_inc_reg)
        else $error("timer increment timing wrong");
    a_sleep_status: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && sleep_op |=> st_to_reg && !st_pd_reg && osc_halt && wdt_reg == '0)
        else $error("sleep status wrong");
endmodule
`default_nettype wire

// [test/cap_bus_model.sv]
// AHB-Lite single-word master standing in for the core sequencer.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module cap_bus_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // ------------------------------------------------------------
    // Bus idle at time zero, then one transfer per call
    // ------------------------------------------------------------
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Holds each phase until hready is seen high; no fixed latency
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the ALU operations and shared prescaler.
// Assumes the bus model as sole master and a short watchdog counter.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cap_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic timer_ext_clock_in = 1'b0;
    logic wake_req = 1'b0;
    logic wdt_tick = 1'b0;
    logic hsel, hwrite, hready, hresp, osc_halt, wdt_timeout;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int mismatches = 0;
    int samples_checked = 0;
    int tout_seen = 0;
    always #12.5 hclk = ~hclk;
    // Counts one-cycle watchdog timeout pulses
    always @(posedge hclk) if (wdt_timeout === 1'b1) tout_seen++;
    // Two-bit watchdog keeps overflow within a handful of steps
    cap_core #(.WDT_W(2)) u_cap_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .timer_ext_clock_in(timer_ext_clock_in), .wdt_enable(1'b1),
        .wdt_tick(wdt_tick), .wake_req(wake_req), .osc_halt(osc_halt), .wdt_timeout(wdt_timeout));
    cap_bus_model u_host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        u_host.xfer(1'b1, {20'h0, i, 2'h0}, d, rd);
    endtask
    task automatic rc(input logic [9:0] i, input logic [31:0] e);
        u_host.xfer(1'b0, {20'h0, i, 2'h0}, 32'h0, rd);
        chk($sformatf("reg %h", i), rd, e);
    endtask
    task automatic ex(input logic [13:0] op);
        wr(IDX_INSTR, {18'h0, op});
    endtask
    // Watchdog steps, one cycle high and one low each
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge hclk) wdt_tick <= 1'b1;
            @(posedge hclk) wdt_tick <= 1'b0;
        end
    endtask
    // Pin held 8 cycles each level, well above the 4-cycle minimum
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge hclk) timer_ext_clock_in <= 1'b1;
            repeat (8) @(posedge hclk);
            timer_ext_clock_in <= 1'b0;
            repeat (8) @(posedge hclk);
        end
        repeat (12) @(posedge hclk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_alu;
        rc(IDX_OPTION, 32'hFF);
        rc(10'h3FF, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        wr(IDX_ACC, 32'hFF);
        ex({OPC_ADD_LIT, 9'h001});
        rc(IDX_ACC, 32'h00);
        rc(IDX_STATUS, 32'h1F);
        wr(IDX_FADDR, 32'h20);
        wr(IDX_FDATA, 32'hC2);
        wr(IDX_ACC, 32'h17);
        ex({OPC_ADD_REG, 1'b1, 7'h20});
        rc(IDX_FDATA, 32'hD9);
        rc(IDX_ACC, 32'h17);
        rc(IDX_STATUS, 32'h18);
        wr(IDX_ACC, 32'hA3);
        wr(IDX_STATUS, 32'h01);
        ex({OPC_AND_REG, 1'b1, 7'h20});
        rc(IDX_FDATA, 32'h81);
        rc(IDX_STATUS, 32'h19);
        ex({OPC_AND_LIT, 8'h5C});
        rc(IDX_ACC, 32'h00);
        rc(IDX_STATUS, 32'h1D);
        ex({OPC_ROT_RIGHT, 1'b0, 7'h20});
        rc(IDX_ACC, 32'hC0);
        rc(IDX_STATUS, 32'h1D);
        wr(IDX_ACC, 32'h03);
        ex({OPC_SUB_LIT, 9'h002});
        rc(IDX_ACC, 32'hFF);
        rc(IDX_STATUS, 32'h18);
        wr(IDX_ACC, 32'h02);
        ex({OPC_SUB_LIT, 9'h002});
        rc(IDX_STATUS, 32'h1F);
        $display("test alu done");
    endtask
    task automatic t_timer;
        wr(IDX_OPTION, 32'h28);
        wr(IDX_TIMER, 32'h0);
        @(posedge hclk) timer_ext_clock_in <= 1'b1;
        rc(IDX_TIMER, 32'h0);
        pulse(2);
        rc(IDX_TIMER, 32'h2);
        wr(IDX_OPTION, 32'h20);
        wr(IDX_TIMER, 32'h0);
        pulse(1);
        wr(IDX_TIMER, 32'h0);
        pulse(1);
        // Divide by two counts on the first edge after a clear
        rc(IDX_TIMER, 32'h1);
        pulse(1);
        rc(IDX_TIMER, 32'h1);
        $display("test timer done");
    endtask
    task automatic t_sleep;
        wr(IDX_OPTION, 32'h08);
        tick(3);
        ex(OPC_WDT_CLEAR);
        rc(IDX_STATUS, 32'h1F);
        ex(OPC_SLEEP);
        rc(IDX_STATUS, 32'h37);
        ex(OPC_WDT_CLEAR);
        rc(IDX_STATUS, 32'h37);
        chk("osc_halt", {31'h0, osc_halt}, 32'h1);
        @(posedge hclk) wake_req <= 1'b1;
        @(posedge hclk) wake_req <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("osc_halt", {31'h0, osc_halt}, 32'h0);
        tick(3);
        chk("wdt_timeout", tout_seen, 32'h0);
        tick(1);
        rc(IDX_STATUS, 32'h07);
        chk("wdt_timeout", tout_seen, 32'h1);
        $display("test sleep done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_alu();
        t_timer();
        t_sleep();
        results();
    end
    // Tests need well under 2000 cycles
    initial begin
        #500000;
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
